// ### logic/dbg_match_pkg.sv
// Constants, types and carrier structs for the debug event matcher.
package dbg_match_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CH = 12;
  localparam int CNT_W  = 16;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_GCTRL  = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_MASK   = 12'h008;
  localparam logic [11:0] OFF_STATE  = 12'h00c;
  // Channel n occupies CH_PAGE:n:word, word index below.
  localparam logic [3:0]  CH_PAGE    = 4'h1;
  localparam logic [1:0]  CH_CTRL    = 2'h0;
  localparam logic [1:0]  CH_VAL     = 2'h1;
  localparam logic [1:0]  CH_VAL2    = 2'h2;
  localparam logic [1:0]  CH_CNT     = 2'h3;

  // ==========================================================================
  // Field positions
  localparam int GC_SWTRACE  = 0;
  localparam int GC_SWBP     = 1;
  localparam int CTL_EN      = 0;
  localparam int CTL_COND    = 1;
  localparam int CTL_SIZE    = 4;
  localparam int CTL_RW      = 6;
  localparam int CTL_BRK     = 8;
  localparam int CTL_TRC     = 9;
  localparam int CTL_PSTART  = 10;
  localparam int CTL_PEND    = 11;
  localparam int CTL_BRTYPE  = 12;
  localparam int ST_BREAK    = 12;
  localparam int ST_DBGRST   = 13;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] GCTRL_RST   = 32'h00000000;
  localparam logic [31:0] MASK_RST    = 32'h00000000;
  localparam logic [31:0] CH_CTRL_RST = 32'h00000000;
  localparam int          BRANCH_CH   = 11;
  // Enabled, branch condition, trace action.
  localparam logic [31:0] BR_CTRL_RST = 32'h0000020d;

  // ==========================================================================
  // Encodings
  typedef enum logic [2:0] {
    COND_ADDR   = 3'h0,
    COND_DATA   = 3'h1,
    COND_BUS    = 3'h2,
    COND_WINDOW = 3'h3,
    COND_SYSBUS = 3'h4,
    COND_TLB    = 3'h5,
    COND_BRANCH = 3'h6
  } cond_e;

  typedef enum logic [1:0] {
    RW_ANY   = 2'h0,
    RW_READ  = 2'h1,
    RW_WRITE = 2'h2
  } rw_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_e;

  typedef enum logic [1:0] {
    BRK_RUN    = 2'b00,
    BRK_ARMED  = 2'b01,
    BRK_HALTED = 2'b11
  } brk_state_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        access;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] data;
    logic        fetch;
    logic [31:0] pc;
    logic        xy_access;
    logic [31:0] xaddr;
    logic [31:0] yaddr;
    logic        sys_access;
    logic        sys_write;
    logic [31:0] sys_addr;
    logic [31:0] sys_data;
    logic        tlb_load_instruction;
    logic        branch;
    logic [2:0]  branch_type;
    logic        insn_boundary;
    logic        sw_trace;
  } cpu_obs_s;

  typedef struct packed {
    logic        req;
    logic        write;
  } dbg_acc_s;

  typedef struct packed {
    logic        lru_hold;
    logic        cache_update;
    logic        ext_single_write;
    logic        read_from_cache;
  } cache_ctl_s;

  typedef struct packed {
    logic        stb;
    logic [3:0]  event_channel_index;
    logic        sw;
    logic        perf_start;
    logic        perf_end;
  } trace_s;

endpackage

// ### logic/debug_event_break_matcher.sv
// Debug event matcher with break control, cache hooks and register slave.
//
// Functional notes
// R1 - Twelve event channels plus software-trace selector.
// R2 - Address matches address bus or program counter.
// R3 - Data match with byte, word, longword size.
// R4 - Bus state matches data or X/Y address.
// R5 - Read/write qualifier restricts access direction.
// R6 - Window fires on access inside address range.
// R7 - System bus address or data match.
// R8 - TLB load instruction always forces break.
// R9 - Count qualifier delays action until count reached.
// R10 - Branch condition; trace enabled after reset.
// R11 - Action selects break, trace, perf start/end.
// R12 - Break write: cache update, single write, LRU kept.
// R13 - Break read: from cache, LRU kept.
// R14 - Software breakpoint disables instruction cache.
// R15 - Debug port reset spares clock generator, watchdog.
// R16 - Break request halts at next instruction boundary.
`timescale 1ns/1ns

module debug_event_break_matcher (
  // Clock and reset
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_N,
  // Register bus
  input  wire logic [11:0]                   S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [31:0]                   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [11:0]                   S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [31:0]                        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY,
  // Processor observation and break handshake
  input  wire dbg_match_pkg::cpu_obs_s       CPU_OBS,
  input  wire logic                          CPU_IN_BREAK,
  output logic                               BREAK_REQ,
  // Trace and performance actions
  output dbg_match_pkg::trace_s              TRACE,
  // Debugger memory access and cache
  input  wire dbg_match_pkg::dbg_acc_s       DBG_ACC,
  input  wire logic                          CACHE_EN,
  output dbg_match_pkg::cache_ctl_s          CACHE_CTL,
  output logic                               ICACHE_DISABLE,
  // Serial debug port reset
  input  wire logic                          SERIAL_DEBUG_PORT_RST_REQ,
  output logic                               CORE_RST,
  output logic                               CPG_WDT_RST,
  // Interrupt
  output logic                               IRQ
);

  localparam int N = dbg_match_pkg::NUM_CH;

  // ==========================================================================
  // Register state
  logic [31:0]                     gctrl;
  logic [31:0]                     status;
  logic [31:0]                     mask;
  logic [31:0]                     ch_ctrl [N];
  logic [31:0]                     ch_val  [N];
  logic [31:0]                     ch_val2 [N];
  logic [31:0]                     ch_cnt  [N];
  logic [dbg_match_pkg::CNT_W-1:0] hits    [N];
  dbg_match_pkg::brk_state_e       state;
  dbg_match_pkg::brk_state_e       next_state;

  // ==========================================================================
  // Bus slave handshake
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  wire aw_hs  = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs   = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_hs  = S_AXI_ARVALID & S_AXI_ARREADY;
  wire wr_go  = aw_held & w_held & ~S_AXI_BVALID;
  wire next_aw_held = aw_hs | (aw_held & ~wr_go);
  wire next_w_held  = w_hs | (w_held & ~wr_go);
  wire next_rvalid  = ar_hs | (S_AXI_RVALID & ~S_AXI_RREADY);

  // Address decode for both directions.
  wire [3:0] wr_ch   = aw_addr_q[7:4];
  wire [1:0] wr_word = aw_addr_q[3:2];
  wire       wr_chan = (aw_addr_q[11:8] == dbg_match_pkg::CH_PAGE) && (wr_ch < 4'(N));
  wire       wr_gc   = aw_addr_q == dbg_match_pkg::OFF_GCTRL;
  wire       wr_mask = aw_addr_q == dbg_match_pkg::OFF_MASK;
  wire       wr_ok   = wr_chan || wr_gc || wr_mask ||
                       aw_addr_q == dbg_match_pkg::OFF_STATUS ||
                       aw_addr_q == dbg_match_pkg::OFF_STATE;
  wire [3:0] rd_ch   = S_AXI_ARADDR[7:4];
  wire       rd_chan = (S_AXI_ARADDR[11:8] == dbg_match_pkg::CH_PAGE) && (rd_ch < 4'(N));
  wire       rd_stat = S_AXI_ARADDR == dbg_match_pkg::OFF_STATUS;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    if (rd_chan) begin
      case (S_AXI_ARADDR[3:2])
        dbg_match_pkg::CH_CTRL: rd_val = ch_ctrl[rd_ch];
        dbg_match_pkg::CH_VAL:  rd_val = ch_val[rd_ch];
        dbg_match_pkg::CH_VAL2: rd_val = ch_val2[rd_ch];
        default:                rd_val = ch_cnt[rd_ch];
      endcase
    end else begin
      case (S_AXI_ARADDR)
        dbg_match_pkg::OFF_GCTRL:  rd_val = gctrl;
        dbg_match_pkg::OFF_STATUS: rd_val = status;
        dbg_match_pkg::OFF_MASK:   rd_val = mask;
        dbg_match_pkg::OFF_STATE:  rd_val = {29'h0, ICACHE_DISABLE, state};
        default:                   rd_ok  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RRESP   <= 2'b00;
      S_AXI_RDATA   <= 32'h00000000;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      S_AXI_AWREADY <= ~next_aw_held;
      S_AXI_WREADY  <= ~next_w_held;
      S_AXI_ARREADY <= ~next_rvalid;
      S_AXI_RVALID  <= next_rvalid;
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (ar_hs) begin
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? 2'b00 : 2'b10;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (aw_hs) begin
      aw_addr_q <= S_AXI_AWADDR;
    end
    if (w_hs) begin
      w_data_q <= S_AXI_WDATA;
      w_strb_q <= S_AXI_WSTRB;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      gctrl <= dbg_match_pkg::GCTRL_RST;
      mask  <= dbg_match_pkg::MASK_RST;
      for (int i = 0; i < N; i++) begin
        ch_ctrl[i] <= (i == dbg_match_pkg::BRANCH_CH) ? dbg_match_pkg::BR_CTRL_RST
                                                      : dbg_match_pkg::CH_CTRL_RST; // R10
        ch_val[i]  <= 32'h00000000;
        ch_val2[i] <= 32'h00000000;
        ch_cnt[i]  <= 32'h00000000;
      end
    end else if (wr_go) begin
      if (wr_gc) begin
        gctrl <= merge(gctrl, w_data_q, w_strb_q);
      end
      if (wr_mask) begin
        mask <= merge(mask, w_data_q, w_strb_q);
      end
      if (wr_chan) begin
        case (wr_word)
          dbg_match_pkg::CH_CTRL: ch_ctrl[wr_ch] <= merge(ch_ctrl[wr_ch], w_data_q, w_strb_q);
          dbg_match_pkg::CH_VAL:  ch_val[wr_ch]  <= merge(ch_val[wr_ch], w_data_q, w_strb_q);
          dbg_match_pkg::CH_VAL2: ch_val2[wr_ch] <= merge(ch_val2[wr_ch], w_data_q, w_strb_q);
          default:                ch_cnt[wr_ch]  <= merge(ch_cnt[wr_ch], w_data_q, w_strb_q);
        endcase
      end
    end
  end

  // ==========================================================================
  // Event channels
  logic [N-1:0] fire;
  logic [N-1:0] brk_v;
  logic [N-1:0] trc_v;
  logic [N-1:0] ps_v;
  logic [N-1:0] pe_v;

  for (genvar g = 0; g < N; g++) begin : g_ch
    wire [31:0] c    = ch_ctrl[g];
    wire [31:0] v    = ch_val[g];
    wire [2:0]  cond = c[dbg_match_pkg::CTL_COND +: 3];
    wire [1:0]  sz   = c[dbg_match_pkg::CTL_SIZE +: 2];
    wire [1:0]  rw   = c[dbg_match_pkg::CTL_RW +: 2];
    wire [31:0] msk  = (sz == dbg_match_pkg::SZ_BYTE) ? 32'h000000ff :
                       (sz == dbg_match_pkg::SZ_WORD) ? 32'h0000ffff : 32'hffffffff;
    wire        rw_ok = (rw == dbg_match_pkg::RW_ANY) ||
                        (rw == dbg_match_pkg::RW_READ && !CPU_OBS.write) ||
                        (rw == dbg_match_pkg::RW_WRITE && CPU_OBS.write); // R5
    wire        sys_rw = (rw == dbg_match_pkg::RW_ANY) ||
                         (rw == dbg_match_pkg::RW_READ && !CPU_OBS.sys_write) ||
                         (rw == dbg_match_pkg::RW_WRITE && CPU_OBS.sys_write); // R5
    wire        acc   = CPU_OBS.access && rw_ok;
    wire        h_addr = (acc && CPU_OBS.addr == v) ||
                         (CPU_OBS.fetch && CPU_OBS.pc == v); // R2
    wire        h_data = acc && CPU_OBS.size == sz &&
                         (CPU_OBS.data & msk) == (v & msk); // R3
    wire        h_bus  = (acc && CPU_OBS.data == v) ||
                         (CPU_OBS.xy_access && rw_ok &&
                          (CPU_OBS.xaddr == v || CPU_OBS.yaddr == v)); // R4
    wire        h_win  = acc && CPU_OBS.addr >= v && CPU_OBS.addr <= ch_val2[g]; // R6
    wire        h_sys  = CPU_OBS.sys_access && sys_rw &&
                         (CPU_OBS.sys_addr == v || CPU_OBS.sys_data == v); // R7
    wire        h_br   = CPU_OBS.branch &&
                         CPU_OBS.branch_type == c[dbg_match_pkg::CTL_BRTYPE +: 3]; // R10
    logic       raw;
    always_comb begin
      case (cond)
        dbg_match_pkg::COND_ADDR:   raw = h_addr;
        dbg_match_pkg::COND_DATA:   raw = h_data;
        dbg_match_pkg::COND_BUS:    raw = h_bus;
        dbg_match_pkg::COND_WINDOW: raw = h_win;
        dbg_match_pkg::COND_SYSBUS: raw = h_sys;
        dbg_match_pkg::COND_TLB:    raw = CPU_OBS.tlb_load_instruction;
        dbg_match_pkg::COND_BRANCH: raw = h_br;
        default:                    raw = 1'b0;
      endcase
    end
    // A zero count means every match fires; otherwise the Nth match fires and rearms.
    wire [dbg_match_pkg::CNT_W-1:0] lim = ch_cnt[g][dbg_match_pkg::CNT_W-1:0];
    wire [dbg_match_pkg::CNT_W-1:0] nxt = hits[g] + 1'b1;
    wire hit = c[dbg_match_pkg::CTL_EN] && raw;
    assign fire[g]  = hit && (lim == '0 || nxt == lim); // R9
    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        hits[g] <= '0;
      end else if (hit && lim != '0) begin
        hits[g] <= (nxt == lim) ? '0 : nxt; // R9
      end
    end
    assign brk_v[g] = fire[g] && (c[dbg_match_pkg::CTL_BRK] ||
                                  cond == dbg_match_pkg::COND_TLB); // R8 R11
    assign trc_v[g] = fire[g] && c[dbg_match_pkg::CTL_TRC]; // R11
    assign ps_v[g]  = fire[g] && c[dbg_match_pkg::CTL_PSTART]; // R11
    assign pe_v[g]  = fire[g] && c[dbg_match_pkg::CTL_PEND]; // R11
  end

  // Lowest tracing channel wins when several trace in one cycle.
  logic [3:0] trc_idx;
  always_comb begin
    trc_idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (trc_v[i]) begin
        trc_idx = 4'(i);
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      TRACE <= '0;
    end else begin
      TRACE.stb                 <= |trc_v; // R1
      TRACE.event_channel_index <= trc_idx;
      TRACE.sw         <= CPU_OBS.sw_trace && gctrl[dbg_match_pkg::GC_SWTRACE]; // R1
      TRACE.perf_start <= |ps_v;
      TRACE.perf_end   <= |pe_v;
    end
  end

  // ==========================================================================
  // Break control
  logic in_brk_q;
  wire  any_brk   = |brk_v;
  wire  brk_taken = state == dbg_match_pkg::BRK_ARMED && CPU_OBS.insn_boundary;

  always_comb begin
    case (state)
      dbg_match_pkg::BRK_RUN:    next_state = any_brk ? dbg_match_pkg::BRK_ARMED
                                                      : dbg_match_pkg::BRK_RUN;
      dbg_match_pkg::BRK_ARMED:  next_state = brk_taken ? dbg_match_pkg::BRK_HALTED
                                                        : dbg_match_pkg::BRK_ARMED; // R16
      dbg_match_pkg::BRK_HALTED: next_state = (in_brk_q && !CPU_IN_BREAK) ?
                                              dbg_match_pkg::BRK_RUN : dbg_match_pkg::BRK_HALTED;
      default:                   next_state = dbg_match_pkg::BRK_RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state     <= dbg_match_pkg::BRK_RUN;
      in_brk_q  <= 1'b0;
      BREAK_REQ <= 1'b0;
    end else begin
      state     <= next_state;
      in_brk_q  <= CPU_IN_BREAK;
      BREAK_REQ <= brk_taken; // R16
    end
  end

  // ==========================================================================
  // Debugger access and caches
  // Accesses while the core is halted must not disturb replacement state.
  wire dbg_cached = DBG_ACC.req && CPU_IN_BREAK && CACHE_EN;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      CACHE_CTL      <= '0;
      ICACHE_DISABLE <= 1'b0;
    end else begin
      CACHE_CTL.lru_hold         <= dbg_cached; // R12 R13
      CACHE_CTL.cache_update     <= dbg_cached && DBG_ACC.write; // R12
      CACHE_CTL.ext_single_write <= dbg_cached && DBG_ACC.write; // R12
      CACHE_CTL.read_from_cache  <= dbg_cached && !DBG_ACC.write; // R13
      ICACHE_DISABLE             <= gctrl[dbg_match_pkg::GC_SWBP]; // R14
    end
  end

  // ==========================================================================
  // Serial debug port reset
  // The request comes from the debug clock domain and is filtered here.
  logic sdp_s1;
  logic sdp_s2;
  logic sdp_s3;
  logic sdp_lvl;
  wire  sdp_rise = (sdp_s2 == sdp_s3) && sdp_s2 && !sdp_lvl;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sdp_s1      <= 1'b0;
      sdp_s2      <= 1'b0;
      sdp_s3      <= 1'b0;
      sdp_lvl     <= 1'b0;
      CORE_RST    <= 1'b0;
      CPG_WDT_RST <= 1'b1;
    end else begin
      sdp_s1      <= SERIAL_DEBUG_PORT_RST_REQ;
      sdp_s2      <= sdp_s1;
      sdp_s3      <= sdp_s2;
      if (sdp_s2 == sdp_s3) begin
        sdp_lvl <= sdp_s2;
      end
      CORE_RST    <= sdp_rise;
      // Only the system reset reaches the clock generator and watchdog.
      CPG_WDT_RST <= 1'b0; // R15
    end
  end

  // ==========================================================================
  // Interrupt status
  wire [31:0] events = {18'h0, sdp_rise, brk_taken, fire};
  wire [31:0] clr    = (ar_hs && rd_stat) ? 32'hffffffff : 32'h00000000;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      status <= 32'h00000000;
      IRQ    <= 1'b0;
    end else begin
      status <= (status & ~clr) | events;
      IRQ    <= |(((status & ~clr) | events) & mask);
    end
  end

endmodule

// ### sim/dbg_check_monitor.sv
// Assertion checker bound to the debug event matcher.
`timescale 1ns/1ns
module dbg_check_monitor (
  // Clock and reset
  input wire logic                      CLK_SYS,
  input wire logic                      RST_N,
  // Watched ports
  input wire dbg_match_pkg::cpu_obs_s   CPU_OBS,
  input wire logic                      CPU_IN_BREAK,
  input wire logic                      BREAK_REQ,
  input wire dbg_match_pkg::trace_s     TRACE,
  input wire dbg_match_pkg::dbg_acc_s   DBG_ACC,
  input wire logic                      CACHE_EN,
  input wire dbg_match_pkg::cache_ctl_s CACHE_CTL,
  input wire logic                      SERIAL_DEBUG_PORT_RST_REQ,
  input wire logic                      CORE_RST,
  input wire logic                      CPG_WDT_RST
);
  // ================
  // Properties
  wire dbg_ok = DBG_ACC.req && CPU_IN_BREAK && CACHE_EN;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  cache_write_a: assert property (
    dbg_ok && DBG_ACC.write |=> CACHE_CTL == 4'he) else $error("Bad write hooks.");
  cache_read_a: assert property (
    dbg_ok && !DBG_ACC.write |=> CACHE_CTL == 4'h9) else $error("Bad read hooks.");
  cache_idle_a: assert property (!dbg_ok |=> CACHE_CTL == 4'h0)
    else $error("Stray cache hooks.");
  brk_pulse_a: assert property (BREAK_REQ |=> !BREAK_REQ)
    else $error("Long break request.");
  brk_bound_a: assert property ($rose(BREAK_REQ) |-> $past(CPU_OBS.insn_boundary))
    else $error("Break off boundary.");
  port_rst_a: assert property ($rose(SERIAL_DEBUG_PORT_RST_REQ) |-> ##[1:6] CORE_RST)
    else $error("No core reset.");
  core_once_a: assert property (CORE_RST |=> !CORE_RST)
    else $error("Long core reset.");
  wdt_keep_a: assert property ($past(RST_N) |-> !CPG_WDT_RST)
    else $error("Watchdog reset hit.");
  trace_idx_a: assert property (TRACE.stb |-> TRACE.event_channel_index < 4'hc)
    else $error("Bad channel index.");
  cover property (BREAK_REQ);
  cover property (TRACE.stb);
  cover property (CORE_RST);
endmodule
bind debug_event_break_matcher dbg_check_monitor dbg_check_monitor_i (
  .CLK_SYS, .RST_N, .CPU_OBS, .CPU_IN_BREAK, .BREAK_REQ, .TRACE, .DBG_ACC, .CACHE_EN,
  .CACHE_CTL, .SERIAL_DEBUG_PORT_RST_REQ, .CORE_RST, .CPG_WDT_RST);

// ### sim/cpu_core_model.sv
// Behavioural processor core that halts on a break request.
`timescale 1ns/1ns
module cpu_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Break handshake
  input  wire logic brk,
  input  wire logic resume,
  output logic      in_break,
  output logic      boundary
);
  // ================
  // Core state
  logic [1:0] phase;
  // Boundaries come only every fourth cycle, so an armed break has to wait.
  assign boundary = (phase == 2'h0) && !in_break;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase    <= 2'h0;
      in_break <= 1'h0;
    end else begin
      phase <= phase + 2'h1;
      if (brk)
        in_break <= 1'h1;
      else if (resume)
        in_break <= 1'h0;
    end
  end
endmodule

// ### sim/debug_event_break_matcher_test.sv
// Register-level testbench for the debug event matcher.
`timescale 1ns/1ns
module debug_event_break_matcher_test;
  // ================
  // Signals
  logic                       clk = 1'h0;
  logic                       rst_n = 1'h0;
  logic [11:0]                aw_addr = 12'h0;
  logic [11:0]                ar_addr = 12'h0;
  logic [31:0]                w_data = 32'h0;
  logic                       aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic                       aw_rdy, w_rdy, b_v, ar_rdy, r_v, in_brk, bound, brk, icd, irq;
  logic                       core_rst, wdt_rst, seen;
  logic                       dp_rst = 1'h0, resume = 1'h0, c_en = 1'h0;
  logic [1:0]                 b_resp, r_resp, wr_r, rd_r;
  logic [31:0]                r_data;
  dbg_match_pkg::cpu_obs_s    obs = '0, obs_w, o;
  dbg_match_pkg::trace_s      trc;
  dbg_match_pkg::dbg_acc_s    acc = '0;
  dbg_match_pkg::cache_ctl_s  cc;
  int                         err_count = 0, total_checks = 0, cycles = 0;

  always #5 clk = ~clk;
  always_comb begin
    obs_w = obs;
    obs_w.insn_boundary = bound;
  end

  debug_event_break_matcher debug_event_break_matcher_i (
    .CLK_SYS(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
    .CPU_OBS(obs_w), .CPU_IN_BREAK(in_brk), .BREAK_REQ(brk), .TRACE(trc),
    .DBG_ACC(acc), .CACHE_EN(c_en), .CACHE_CTL(cc), .ICACHE_DISABLE(icd),
    .SERIAL_DEBUG_PORT_RST_REQ(dp_rst), .CORE_RST(core_rst), .CPG_WDT_RST(wdt_rst),
    .IRQ(irq));
  cpu_core_model cpu_core_model_i (.clk(clk), .rst_n(rst_n), .brk(brk), .resume(resume),
    .in_break(in_brk), .boundary(bound));

  // ================
  // Tasks
  task final_report;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_r <= 1'h1;
    do begin
      @(posedge clk);
      if (aw_rdy) aw_v <= 1'h0;
      if (w_rdy) w_v <= 1'h0;
    end while (b_v !== 1'h1);
    b_r <= 1'h0;
    wr_r = b_resp;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    ar_addr <= a;
    ar_v <= 1'h1;
    r_r <= 1'h1;
    do begin
      @(posedge clk);
      if (ar_rdy) ar_v <= 1'h0;
    end while (r_v !== 1'h1);
    r_r <= 1'h0;
    chk(r_data, e);
    rd_r = r_resp;
  endtask
  task cfg(input logic [3:0] n, input logic [31:0] c, v, v2, cnt);
    wr({4'h1, n, 4'h0}, c);
    wr({4'h1, n, 4'h4}, v);
    wr({4'h1, n, 4'h8}, v2);
    wr({4'h1, n, 4'hc}, cnt);
  endtask
  function dbg_match_pkg::cpu_obs_s mk(input logic [31:0] a, d, logic [1:0] s, logic w);
    mk = '0;
    mk.access = 1'h1;
    mk.addr = a;
    mk.data = d;
    mk.size = s;
    mk.write = w;
  endfunction
  // Drive one cycle of activity, then check the trace pulse.
  task hit(input dbg_match_pkg::cpu_obs_s ob, input logic [7:0] e);
    @(posedge clk);
    obs <= ob;
    @(posedge clk);
    obs <= '0;
    #1;
    chk(trc, e);
  endtask
  task wait_p(input logic sel);
    seen = 1'h0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if ((sel ? core_rst : brk) === 1'h1) seen = 1'h1;
    end
    chk(seen, 32'h1);
  endtask
  task cache(input logic w, en, input logic [3:0] e);
    @(posedge clk);
    acc <= '{1'h1, w};
    c_en <= en;
    @(posedge clk);
    acc <= '0;
    #1;
    chk(cc, e);
  endtask
  task go_on;
    @(posedge clk);
    resume <= 1'h1;
    @(posedge clk);
    resume <= 1'h0;
  endtask

  // ================
  // Sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    chk(wdt_rst, 32'h1);
    rst_n <= 1'h1;
    rd(12'h1b0, 32'h0000020d);
    rd(12'h0f0, 32'h0);
    chk(rd_r, 32'h2);
    wr(12'h0f0, 32'h1);
    chk(wr_r, 32'h2);
    cfg(4'h0, 32'h101, 32'h1234, 32'h0, 32'h0);
    o = '0;
    o.fetch = 1'h1;
    o.pc = 32'h1234;
    hit(o, 8'h00);
    wait_p(1'h0);
    rd(12'h004, 32'h1001);
    go_on;
    wr(12'h100, 32'h0);
    cfg(4'h1, 32'h223, 32'hcafe0001, 32'h0, 32'h0);
    hit(mk(32'h0, 32'hcafe0001, 2'h2, 1'h0), {1'h1, 4'h1, 3'h0});
    hit(mk(32'h0, 32'hcafe0001, 2'h0, 1'h0), 8'h00);
    cfg(4'h2, 32'h287, 32'h100, 32'h1ff, 32'h0);
    hit(mk(32'h180, 32'h0, 2'h2, 1'h1), {1'h1, 4'h2, 3'h0});
    hit(mk(32'h180, 32'h0, 2'h2, 1'h0), 8'h00);
    hit(mk(32'h200, 32'h0, 2'h2, 1'h1), 8'h00);
    cfg(4'h3, 32'h205, 32'h7000, 32'h0, 32'h0);
    o = '0;
    o.xy_access = 1'h1;
    o.yaddr = 32'h7000;
    hit(o, {1'h1, 4'h3, 3'h0});
    cfg(4'h4, 32'h601, 32'h40, 32'h0, 32'h3);
    repeat (2) hit(mk(32'h40, 32'h0, 2'h2, 1'h0), 8'h00);
    hit(mk(32'h40, 32'h0, 2'h2, 1'h0), {1'h1, 4'h4, 3'h2});
    cfg(4'h6, 32'ha09, 32'h9000, 32'h0, 32'h0);
    o = '0;
    o.sys_access = 1'h1;
    o.sys_addr = 32'h9000;
    hit(o, {1'h1, 4'h6, 3'h1});
    o = '0;
    o.branch = 1'h1;
    hit(o, {1'h1, 4'hb, 3'h0});
    wr(12'h000, 32'h1);
    o = '0;
    o.sw_trace = 1'h1;
    hit(o, 8'h04);
    wr(12'h008, 32'h1000);
    chk(irq, 32'h0);
    cfg(4'h5, 32'hb, 32'h0, 32'h0, 32'h0);
    o = '0;
    o.tlb_load_instruction = 1'h1;
    hit(o, 8'h00);
    wait_p(1'h0);
    chk(irq, 32'h1);
    rd(12'h00c, 32'h3);
    cache(1'h1, 1'h1, 4'he);
    cache(1'h0, 1'h1, 4'h9);
    cache(1'h1, 1'h0, 4'h0);
    rd(12'h004, 32'h187e);
    @(posedge clk);
    #1;
    chk(irq, 32'h0);
    go_on;
    wr(12'h000, 32'h2);
    @(posedge clk);
    #1;
    chk(icd, 32'h1);
    @(posedge clk);
    dp_rst <= 1'h1;
    wait_p(1'h1);
    @(posedge clk);
    dp_rst <= 1'h0;
    chk(wdt_rst, 32'h0);
    rd(12'h114, 32'hcafe0001);
    final_report;
  end
endmodule
